// ===== logic/period_timer_pkg.sv
// Constants shared by the period match timer files
package period_timer_pkg;
  // Register byte offsets on APB
  localparam logic [7:0] OFS_TIMER_COUNT  = 8'h00;
  localparam logic [7:0] OFS_TIMER_PERIOD = 8'h04;
  localparam logic [7:0] OFS_TIMER_CTRL   = 8'h08;
  localparam logic [7:0] OFS_IRQ_FLAGS    = 8'h0c;
  localparam logic [7:0] OFS_IRQ_ENABLES  = 8'h10;
  localparam logic [7:0] OFS_IRQ_PRIORITY = 8'h14;
  // Reset values
  localparam logic [7:0] RST_COUNT    = 8'h00;
  localparam logic [7:0] RST_PERIOD   = 8'hff;
  localparam logic [7:0] RST_CTRL     = 8'h00;
  localparam logic [7:0] RST_FLAGS    = 8'h00;
  localparam logic [7:0] RST_ENABLES  = 8'h00;
  localparam logic [7:0] RST_PRIORITY = 8'h3f;
  // Field positions
  localparam int CTRL_CKPS_LSB = 0;
  localparam int CTRL_RUN_BIT  = 2;
  localparam int CTRL_OUTPS_LSB = 3;
  localparam int IRQ_MATCH_BIT = 3;
  // Writable masks
  localparam logic [7:0] CTRL_MASK = 8'h7f;
  localparam logic [7:0] IRQ3_MASK = 8'h3f;
  // Instruction clock is the system clock divided by this plus one
  localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
  // Prescale terminal counts (divide minus one)
  localparam logic [3:0] PRE_LAST_1  = 4'h0;
  localparam logic [3:0] PRE_LAST_4  = 4'h3;
  localparam logic [3:0] PRE_LAST_16 = 4'hf;
endpackage

// ===== logic/timer_ctl_if.sv
// Control and event signals between the timer core and its register file
`timescale 1ns/1ns
`default_nettype none
interface timer_ctl_if;
  logic       run;
  logic [1:0] ckps;
  logic [3:0] outps;
  logic       scaler_clr;
  logic       tick;
  logic       post_evt;
  modport core (input run, ckps, outps, scaler_clr, output tick, post_evt);
  modport regs (output run, ckps, outps, scaler_clr, input tick, post_evt);
endinterface
`default_nettype wire

// ===== logic/timer_scaler.sv
// Prescaler and postscaler counters of the period match timer
`timescale 1ns/1ns
`default_nettype none
module timer_scaler
  import period_timer_pkg::*;
(
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // Match from the count register
  input  wire logic i_match,
  // Control
  timer_ctl_if.core ctl
);
  typedef struct packed {
    logic [1:0] instr;
    logic [3:0] pre;
    logic [3:0] post;
  } scal_s;

  scal_s st_r;
  scal_s st_nxt;
  logic [3:0] pre_last;

  function automatic logic [3:0] pre_decode(input logic [1:0] sel);
    if (sel[1]) begin
      return PRE_LAST_16;
    end
    return sel[0] ? PRE_LAST_4 : PRE_LAST_1;
  endfunction

  always_comb begin
    st_nxt = st_r;
    pre_last = pre_decode(ctl.ckps);
    ctl.tick = 1'b0;
    ctl.post_evt = 1'b0;
    if (ctl.run) begin
      st_nxt.instr = st_r.instr + 2'h1;
      if (st_r.instr == INSTR_DIV_LAST) begin
        if (st_r.pre >= pre_last) begin
          st_nxt.pre = 4'h0;
          ctl.tick = 1'b1;
        end else begin
          st_nxt.pre = st_r.pre + 4'h1;
        end
      end
    end
    if (i_match) begin
      if (st_r.post >= ctl.outps) begin
        st_nxt.post = 4'h0;
        ctl.post_evt = 1'b1;
      end else begin
        st_nxt.post = st_r.post + 4'h1;
      end
    end
    if (ctl.scaler_clr) begin
      st_nxt.pre = 4'h0;
      st_nxt.post = 4'h0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  a_pre_bounded: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    st_r.pre <= PRE_LAST_16) else $error("prescaler out of range");
  a_post_clears: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ctl.scaler_clr |=> st_r.post == 4'h0) else $error("postscaler not cleared");
endmodule
`default_nettype wire

// ===== logic/period_match_timer_8bit.sv
// Period match timer with APB register file
// Function
// - Count instruction clock through prescaler 1, 4 or 16 by two select bits.
// - Four-bit postscaler divides match events by select value plus one.
// - Each postscaled match sets match flag, bit 3 of flag register.
// - Control bit 2 runs the timer; zero stops it.
// - Count register is software read/write and resets to zero.
// - Count write, control write or reset clears both scaler counters.
// - Control write leaves the count unchanged.
// - Count rises from zero to period then returns to zero.
// - Period register is software read/write.
// - Period register resets to FFh.
// - Unscaled match goes to PWM units as time base and to the postscaler.
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module period_match_timer_8bit
  import period_timer_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output var  logic [31:0] o_prdata,
  output var  logic        o_pready,
  output var  logic        o_pslverr,
  // Device side
  output var  logic        o_pwm_time_base,
  output var  logic        o_match_irq_req,
  output var  logic        o_match_irq_priority
);
  typedef struct packed {
    logic [7:0]  count;
    logic [7:0]  period;
    logic [7:0]  ctrl;
    logic [7:0]  flags;
    logic [7:0]  enables;
    logic [7:0]  priority_r;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        time_base;
    logic        irq_req;
    logic        clr;
  } tmr_s;

  tmr_s st_r;
  tmr_s st_nxt;
  timer_ctl_if ctl ();
  logic match;
  logic setup;
  logic wr;
  logic lane0;
  logic [7:0] wbyte;

  function automatic logic is_mapped(input logic [7:0] a);
    return a == OFS_TIMER_COUNT || a == OFS_TIMER_PERIOD || a == OFS_TIMER_CTRL
        || a == OFS_IRQ_FLAGS || a == OFS_IRQ_ENABLES || a == OFS_IRQ_PRIORITY;
  endfunction

  timer_scaler u_scaler (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_match (match),
    .ctl     (ctl.core)
  );

  assign ctl.run = st_r.ctrl[CTRL_RUN_BIT];
  assign ctl.ckps = st_r.ctrl[CTRL_CKPS_LSB +: 2];
  assign ctl.outps = st_r.ctrl[CTRL_OUTPS_LSB +: 4];
  assign ctl.scaler_clr = st_r.clr;
  assign match = ctl.tick && (st_r.count == st_r.period);
  assign setup = i_psel && !i_penable;
  assign wr = i_psel && i_penable && i_pwrite && st_r.pready;
  assign lane0 = i_pstrb[0];
  assign wbyte = i_pwdata[7:0];

  always_comb begin
    st_nxt = st_r;
    st_nxt.clr = 1'b0;
    st_nxt.time_base = 1'b0;
    st_nxt.pready = 1'b0;
    st_nxt.pslverr = 1'b0;
    if (ctl.tick) begin
      st_nxt.count = match ? 8'h00 : st_r.count + 8'h01;
    end
    st_nxt.time_base = match;
    // Setup phase prepares zero-wait-state answer
    if (setup) begin
      st_nxt.pready = 1'b1;
      st_nxt.pslverr = !is_mapped(i_paddr);
      st_nxt.prdata = 32'h0;
      if (!i_pwrite) begin
        unique case (i_paddr)
          OFS_TIMER_COUNT:  st_nxt.prdata[7:0] = st_r.count;
          OFS_TIMER_PERIOD: st_nxt.prdata[7:0] = st_r.period;
          OFS_TIMER_CTRL:   st_nxt.prdata[7:0] = st_r.ctrl;
          OFS_IRQ_FLAGS:    st_nxt.prdata[7:0] = st_r.flags;
          OFS_IRQ_ENABLES:  st_nxt.prdata[7:0] = st_r.enables;
          OFS_IRQ_PRIORITY: st_nxt.prdata[7:0] = st_r.priority_r;
          default:          st_nxt.prdata = 32'h0;
        endcase
      end
    end
    if (wr && lane0) begin
      unique case (i_paddr)
        OFS_TIMER_COUNT: begin
          st_nxt.count = wbyte;
          st_nxt.clr = 1'b1;
        end
        OFS_TIMER_PERIOD: st_nxt.period = wbyte;
        OFS_TIMER_CTRL: begin
          st_nxt.ctrl = wbyte & CTRL_MASK;
          st_nxt.clr = 1'b1;
        end
        // software clears flag by writing zero
        OFS_IRQ_FLAGS:    st_nxt.flags = wbyte & st_r.flags & IRQ3_MASK;
        OFS_IRQ_ENABLES:  st_nxt.enables = wbyte & IRQ3_MASK;
        OFS_IRQ_PRIORITY: st_nxt.priority_r = wbyte & IRQ3_MASK;
        default:          st_nxt.clr = st_nxt.clr;
      endcase
    end
    // postscaled match sets flag, winning over clear
    if (ctl.post_evt) begin
      st_nxt.flags[IRQ_MATCH_BIT] = 1'b1;
    end
    // request while flag and enable set
    st_nxt.irq_req = st_nxt.flags[IRQ_MATCH_BIT] && st_nxt.enables[IRQ_MATCH_BIT];
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
      st_r.count <= RST_COUNT;
      st_r.period <= RST_PERIOD;
      st_r.ctrl <= RST_CTRL;
      st_r.flags <= RST_FLAGS;
      st_r.enables <= RST_ENABLES;
      st_r.priority_r <= RST_PRIORITY;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_prdata = st_r.prdata;
  assign o_pready = st_r.pready;
  assign o_pslverr = st_r.pslverr;
  assign o_pwm_time_base = st_r.time_base;
  assign o_match_irq_req = st_r.irq_req;
  assign o_match_irq_priority = st_r.priority_r[IRQ_MATCH_BIT];

  a_stop_holds: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !ctl.run && !wr |=> $stable(st_r.count)) else $error("count moved while stopped");
  a_wrap_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    match |=> st_r.count == 8'h00 ##0 st_r.time_base) else $error("no wrap at period");
  a_count_step: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ctl.tick && !match && !(wr && i_paddr == OFS_TIMER_COUNT)
    |=> st_r.count == $past(st_r.count) + 8'h01) else $error("count step wrong");
  a_flag_sets: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ctl.post_evt |=> st_r.flags[IRQ_MATCH_BIT]) else $error("flag not set");
  a_ctrl_keeps: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr && lane0 && i_paddr == OFS_TIMER_CTRL && !ctl.tick
    |=> st_r.count == $past(st_r.count) && st_r.clr) else $error("control write hit count");
  a_count_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr && lane0 && i_paddr == OFS_TIMER_COUNT
    |=> st_r.count == $past(wbyte) ##1 ctl.scaler_clr == 1'b0) else $error("count write");
  a_period_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr && lane0 && i_paddr == OFS_TIMER_PERIOD |=> st_r.period == $past(wbyte))
    else $error("period write lost");
  a_irq_level: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    st_r.flags[IRQ_MATCH_BIT] && st_r.enables[IRQ_MATCH_BIT] |-> o_match_irq_req)
    else $error("request missing");
  a_flag_sticky: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    st_r.flags[IRQ_MATCH_BIT] && !wr |=> st_r.flags[IRQ_MATCH_BIT])
    else $error("flag dropped");
endmodule
`default_nettype wire

// ===== testbench/test_period_match_timer_8bit.sv
// Self-checking bench for the period match timer
`timescale 1ns/1ns
`default_nettype none
module test_period_match_timer_8bit;
  import period_timer_pkg::*;
  logic        i_clk;
  logic        i_rst_n;
  logic        i_psel;
  logic        i_penable;
  logic        i_pwrite;
  logic [7:0]  i_paddr;
  logic [31:0] i_pwdata;
  logic [3:0]  i_pstrb;
  logic [31:0] o_prdata;
  logic        o_pready;
  logic        o_pslverr;
  logic        o_pwm_time_base;
  logic        o_match_irq_req;
  logic        o_match_irq_priority;
  logic [31:0] rd;
  logic        err;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          per;
  int          ops;
  int          n;
  int          k;
  int          pre_div[4] = '{1, 4, 16, 16};

  period_match_timer_8bit u_dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_pwm_time_base(o_pwm_time_base), .o_match_irq_req(o_match_irq_req),
    .o_match_irq_priority(o_match_irq_priority));

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  task automatic close_out();
    $display("Counts: %0d checks, %0d mismatches", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Hang guard, well above the longest expected run
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    i_pstrb <= 4'hf;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk);
      t++;
    end while (o_pready !== 1'b1 && t < 20);
    if (t >= 20) begin
      n_mismatch++;
      close_out();
    end
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // Cycles from one time-base pulse to the next
  task automatic wait_pulse();
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pwm_time_base !== 1'b1 && n < 5000);
    if (n >= 5000) begin
      n_mismatch++;
      close_out();
    end
  endtask

  initial begin
    i_rst_n = 1'b0;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 8'h00;
    i_pwdata = 32'h0;
    i_pstrb = 4'h0;
    void'($urandom(73));
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rdc(OFS_TIMER_COUNT, 32'h00);
    rdc(OFS_TIMER_PERIOD, 32'hff);
    rdc(OFS_TIMER_CTRL, 32'h00);
    rdc(OFS_IRQ_FLAGS, 32'h00);
    rdc(OFS_IRQ_ENABLES, 32'h00);
    rdc(OFS_IRQ_PRIORITY, 32'h3f);
    chk({31'h0, o_match_irq_priority}, 32'h1);
    wr(OFS_IRQ_PRIORITY, 32'h0);
    repeat (2) @(posedge i_clk);
    chk({31'h0, o_match_irq_priority}, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("reset and map test done");
    per = $urandom_range(255);
    wr(OFS_TIMER_PERIOD, 32'(per));
    rdc(OFS_TIMER_PERIOD, 32'(per));
    wr(OFS_TIMER_COUNT, 32'h05);
    wr(OFS_TIMER_CTRL, 32'hfb);
    rdc(OFS_TIMER_CTRL, 32'h7b);
    rdc(OFS_TIMER_COUNT, 32'h05);
    repeat (100) @(posedge i_clk);
    rdc(OFS_TIMER_COUNT, 32'h05);
    $display("register access test done");
    for (int s = 0; s < 4; s++) begin
      per = $urandom_range(3, 1);
      wr(OFS_TIMER_PERIOD, 32'(per));
      wr(OFS_TIMER_COUNT, 32'h0);
      wr(OFS_TIMER_CTRL, 32'(s | 4));
      wait_pulse();
      wait_pulse();
      chk(32'(n), 32'(4 * pre_div[s] * (per + 1)));
    end
    $display("prescale and period test done");
    for (int s = 0; s < 3; s++) begin
      ops = $urandom_range(15);
      wr(OFS_TIMER_CTRL, 32'h0);
      wr(OFS_IRQ_FLAGS, 32'h0);
      wr(OFS_IRQ_ENABLES, 32'h08);
      wr(OFS_TIMER_PERIOD, 32'h1);
      wr(OFS_TIMER_COUNT, 32'h0);
      wr(OFS_TIMER_CTRL, 32'((ops << 3) | 4));
      n = 0;
      k = 0;
      while (o_match_irq_req !== 1'b1 && k < 3000) begin
        @(posedge i_clk);
        k++;
        if (o_pwm_time_base === 1'b1) n++;
      end
      if (k >= 3000) begin
        n_mismatch++;
        close_out();
      end
      chk(32'(n), 32'(ops + 1));
      rdc(OFS_IRQ_FLAGS, 32'h08);
      wr(OFS_TIMER_CTRL, 32'h0);
      rdc(OFS_IRQ_FLAGS, 32'h08);
      wr(OFS_IRQ_FLAGS, 32'h0);
      repeat (2) @(posedge i_clk);
      chk({31'h0, o_match_irq_req}, 32'h0);
    end
    $display("postscale and flag test done");
    close_out();
  end
endmodule
`default_nettype wire
